// file: bench/dssq_ctrl_model.sv
// Purpose: Machine controller driving the enable, stop and safety pins.
// Assumes: Requests are levels on the bench clock.
// Notes:   An emergency stop keeps enable off until run is withdrawn.
`timescale 1ns/1ns
module dssq_ctrl_model (
  // Clock, reset and requests.
  input  wire clk,
  input  wire rst_n,
  input  wire run,
  input  wire stop,
  input  wire estop,
  input  wire tq_ok,
  // Pins towards the drive.
  output reg  hw_en,
  output reg  stop_in,
  output reg  safe_pin
);
  reg held;
  // Stops beat starts; a released emergency stop never restarts alone.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      held     <= 1'b0;
      hw_en    <= 1'b0;
      stop_in  <= 1'b0;
      safe_pin <= 1'b0;
    end else begin
      held     <= estop || (held && run);
      hw_en    <= run && !estop && !held;
      stop_in  <= stop && !estop;
      safe_pin <= tq_ok;
    end
  end
endmodule // dssq_ctrl_model

// file: bench/dssq_top_properties.sv
// Purpose: Port-level properties of the stop and brake sequencer.
// Assumes: The threshold register keeps its reset value.
// Notes:   Pins act about three cycles after they move.
`timescale 1ns/1ns
module dssq_top_properties #(
  parameter TIMEOUT_CYCLES = 50
) (
  // Clock and reset.
  input wire        CLOCK,
  input wire        RSTN,
  // Pins, speed and stage outputs.
  input wire        HARDWARE_ENABLE_INPUT,
  input wire        SAFE_TORQUE_OFF_INPUT,
  input wire [15:0] VELOCITY,
  input wire        POWER_STAGE_ON,
  input wire        DECEL_REQ,
  input wire        BRAKE_APPLY,
  input wire        DRIVE_ACTIVE,
  input wire        UNDERVOLTAGE_FAULT,
  input wire        UNDERVOLTAGE_WARNING,
  input wire        SAFE_TORQUE_FAULT
);
  localparam int BRK_MAX = 70;
  reg [31:0] wait_len;
  wire       stopping = (!POWER_STAGE_ON || DECEL_REQ) && !BRAKE_APPLY;
  default clocking dcb @(posedge CLOCK);
  endclocking
  default disable iff (!RSTN);
  sequence s_cut;
    ##[1:5] !POWER_STAGE_ON;
  endsequence
  sequence s_brake_soon;
    ##[0:BRK_MAX] BRAKE_APPLY;
  endsequence
  // Length of a stop with the brake still open; a stuck timer shows here.
  always @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN)
      wait_len <= 32'h0;
    else if (stopping)
      wait_len <= wait_len + 32'h1;
    else
      wait_len <= 32'h0;
  end
  a_hw_cut: assert property (
    $fell(HARDWARE_ENABLE_INPUT) |-> s_cut) else $error("stage kept on");
  a_torque_cause: assert property (
    $rose(SAFE_TORQUE_FAULT) |-> !$past(SAFE_TORQUE_OFF_INPUT, 2) ||
    !$past(SAFE_TORQUE_OFF_INPUT, 3) || !$past(SAFE_TORQUE_OFF_INPUT, 4))
    else $error("torque fault without cause");
  a_warn_idle: assert property (
    $rose(UNDERVOLTAGE_WARNING) |-> !DRIVE_ACTIVE)
    else $error("warning while active");
  a_uv_cut: assert property (
    $rose(UNDERVOLTAGE_FAULT) |-> ##[0:2] !POWER_STAGE_ON)
    else $error("stage on after undervoltage fault");
  a_decel_power: assert property (
    DECEL_REQ |-> POWER_STAGE_ON && $past(POWER_STAGE_ON))
    else $error("decel without stage");
  a_stop_bound: assert property (
    wait_len <= TIMEOUT_CYCLES + 4) else $error("stop ran past timeout");
  a_slow_brake: assert property (
    DECEL_REQ && VELOCITY == 16'h0 |-> ##[1:2] BRAKE_APPLY)
    else $error("no brake at standstill");
  a_active_brake: assert property (
    $fell(DRIVE_ACTIVE) |-> s_brake_soon) else $error("no brake");
endmodule // dssq_top_properties

// file: bench/dssq_top_tb.sv
// Purpose: Self-checking bench of the stop and brake sequencer.
// Assumes: APB waits for ready; pins act a few cycles after moving.
// Notes:   The stop timeout is cut to TO cycles to keep the run short.
`timescale 1ns/1ns
`include "dssq_consts.vh"
module dssq_top_tb;
  localparam TO = 50;
  logic        clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        run = 0, stq = 0, est = 0, tq = 0, uv = 0, freq = 0;
  logic [1:0]  fcls = 0;
  logic [11:0] paddr = 0;
  logic [15:0] vel = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic        pready, pslverr, err, irq, hen, safe, stp, stage, decel;
  logic        dyn, brake, act, uvf, uvw, stf;
  int          n_errors = 0, checked = 0, k, n;
  dssq_ctrl_model ctrl (.clk(clk), .rst_n(rstn), .run(run), .stop(stq),
    .estop(est), .tq_ok(tq), .hw_en(hen), .stop_in(stp), .safe_pin(safe));
  dssq_top #(.TIMEOUT_CYCLES(TO)) dut (.CLOCK(clk), .RSTN(rstn),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .HARDWARE_ENABLE_INPUT(hen), .SAFE_TORQUE_OFF_INPUT(safe),
    .STOP_INPUT(stp), .UNDERVOLTAGE(uv), .FAULT_REQ(freq),
    .FAULT_CLASS(fcls), .VELOCITY(vel), .POWER_STAGE_ON(stage),
    .DECEL_REQ(decel), .DYN_BRAKE(dyn), .BRAKE_APPLY(brake),
    .DRIVE_ACTIVE(act), .UNDERVOLTAGE_FAULT(uvf),
    .UNDERVOLTAGE_WARNING(uvw), .SAFE_TORQUE_FAULT(stf), .IRQ(irq));
  // Free-running clock at 100 MHz.
  initial begin
    forever #5 clk = ~clk;
  end
  // Hang guard, far beyond the expected run length.
  initial begin
    #200000;
    n_errors++;
    stop_test;
  end
  task automatic stop_test;
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge clk);
  endtask
  // One APB transfer; the request holds until ready is sampled high.
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wbrk(output int c);
    c = 0;
    while (brake !== 1'b1 && c < 200) begin
      c++;
      @(posedge clk);
    end
  endtask
  // A stop seeing this speed closes the brake at once.
  function automatic logic slow(input logic [15:0] v);
    return v < `DSSQ_VTHRESH_RESET;
  endfunction
  // Decel and dynamic brake outputs expected for a fault class.
  function automatic logic [1:0] fexp(input logic [1:0] c);
    return c == `DSSQ_FCLASS_CTL ? 2'b10 : {1'b0, c == `DSSQ_FCLASS_DYN};
  endfunction
  // Clear faults, raise the pins and enable the stage.
  task automatic go(input logic [31:0] ctrl_val);
    apb(1'b1, `DSSQ_ADDR_CTRL, ctrl_val);
    run <= 1'b1;
    tq <= 1'b1;
    uv <= 1'b0;
    vel <= 16'h80;
    cyc(8);
    apb(1'b1, `DSSQ_ADDR_CMD, 32'h4);
    apb(1'b1, `DSSQ_ADDR_CMD, 32'h1);
    cyc(2);
    chk("stage on", 1, stage);
    chk("drive active", 1, act);
  endtask
  initial begin
    k = $urandom(55);
    cyc(6);
    rstn <= 1'b1;
    chk("reset brake", 1, brake);
    apb(1'b0, `DSSQ_ADDR_CTRL, 0);
    chk("ctrl reset", `DSSQ_CTRL_RESET, rd);
    apb(1'b0, `DSSQ_ADDR_TIMEOUT, 0);
    chk("timeout reset", TO, rd);
    apb(1'b0, 12'h020, 0);
    chk("unmapped", 1, err);
    apb(1'b1, `DSSQ_ADDR_INTMASK, 32'h1f);
    // Software disable in mode 0 with brake select set, then mode 2.
    for (k = 0; k < 2; k++) begin
      go(k ? 32'h5 : 32'h9);
      vel <= $urandom % 16'h20;
      apb(1'b1, `DSSQ_ADDR_CMD, 32'h2);
      cyc(4);
      chk("disable stage", k && !slow(vel), stage);
      chk("disable brake", slow(vel), brake);
      vel <= 16'h0;
      wbrk(n);
      chk("standstill brake", 1, n < 4);
    end
    // The brake event raises the interrupt; mask and clear drop it.
    chk("irq", 1, irq);
    apb(1'b1, `DSSQ_ADDR_INTMASK, 0);
    cyc(2);
    chk("irq masked", 0, irq);
    apb(1'b1, `DSSQ_ADDR_INTSTAT, 32'h1f);
    apb(1'b1, `DSSQ_ADDR_INTMASK, 32'h1f);
    cyc(2);
    chk("irq cleared", 0, irq);
    // Stop input at speed decelerates, then brakes on the timeout.
    go(32'h1);
    stq <= 1'b1;
    cyc(6);
    chk("stop decel", 1, decel);
    wbrk(n);
    chk("timeout", 1, n > TO - 12 && n < TO + 2);
    stq <= 1'b0;
    // Hardware disable, then emergency stop with the brake at once.
    for (k = 0; k < 2; k++) begin
      go(k ? 32'h9 : 32'h1);
      if (k)
        est <= 1'b1;
      else
        run <= 1'b0;
      cyc(7);
      chk("hw stage", 0, stage);
      chk("hw brake", k, brake);
      est <= 1'b0;
      cyc(4);
      chk("no restart", 0, hen);
      run <= 1'b0;
      vel <= 16'h0;
      wbrk(n);
      chk("hw stop brake", 1, brake);
    end
    // Each fault class picks its kind of stop; classes 0 and 1 both cut the stage.
    for (k = 0; k < 4; k++) begin
      go(32'h1);
      fcls <= k[1:0];
      freq <= 1'b1;
      cyc(1);
      freq <= 1'b0;
      cyc(3);
      chk("fault kind", fexp(k[1:0]), {decel, dyn});
      if (k != 2)
        chk("fault stage", k == 3, stage);
      vel <= 16'h0;
      wbrk(n);
      chk("fault brake", 1, brake);
    end
    // Enable pin rising while the safety input carries no current.
    run <= 1'b0;
    cyc(4);
    tq <= 1'b0;
    run <= 1'b1;
    cyc(8);
    chk("torque fault", 1, stf);
    run <= 1'b0;
    // Undervoltage while idle warns in mode 1, faults on enable or mode 0.
    uv <= 1'b1;
    cyc(6);
    chk("idle warning", 1, uvw);
    chk("idle no fault", 0, uvf);
    apb(1'b1, `DSSQ_ADDR_CMD, 32'h1);
    cyc(3);
    chk("enable fault", 1, uvf);
    apb(1'b1, `DSSQ_ADDR_CTRL, 32'h0);
    apb(1'b1, `DSSQ_ADDR_CMD, 32'h4);
    cyc(3);
    chk("mode 0 fault", 1, uvf);
    stop_test;
  end
endmodule // dssq_top_tb
bind dssq_top dssq_top_properties #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) props (
  .CLOCK(CLOCK), .RSTN(RSTN), .VELOCITY(VELOCITY),
  .HARDWARE_ENABLE_INPUT(HARDWARE_ENABLE_INPUT),
  .SAFE_TORQUE_OFF_INPUT(SAFE_TORQUE_OFF_INPUT),
  .POWER_STAGE_ON(POWER_STAGE_ON), .DECEL_REQ(DECEL_REQ),
  .BRAKE_APPLY(BRAKE_APPLY), .DRIVE_ACTIVE(DRIVE_ACTIVE),
  .UNDERVOLTAGE_FAULT(UNDERVOLTAGE_FAULT),
  .UNDERVOLTAGE_WARNING(UNDERVOLTAGE_WARNING),
  .SAFE_TORQUE_FAULT(SAFE_TORQUE_FAULT));

// file: design/dssq_consts.vh
// Purpose: Shared constants of the drive stop and brake sequencer.
// Assumes: 100 MHz clock, APB register access with 32-bit words.
// Notes:   Offsets are byte addresses; field positions are bit numbers.
`ifndef DSSQ_CONSTS_VH
`define DSSQ_CONSTS_VH
`define DSSQ_ADDR_CTRL     12'h000
`define DSSQ_ADDR_VTHRESH  12'h004
`define DSSQ_ADDR_TIMEOUT  12'h008
`define DSSQ_ADDR_STATUS   12'h00c
`define DSSQ_ADDR_INTSTAT  12'h010
`define DSSQ_ADDR_INTMASK  12'h014
`define DSSQ_ADDR_VELOCITY 12'h018
`define DSSQ_ADDR_CMD      12'h01c
// Control register fields.
`define DSSQ_CTRL_UVMODE   0
`define DSSQ_CTRL_DISMODE  2:1
`define DSSQ_CTRL_BRKIMM   3
`define DSSQ_CTRL_RESET    32'h0000_0001
// Command register fields, write-one pulses.
`define DSSQ_CMD_ENABLE    0
`define DSSQ_CMD_DISABLE   1
`define DSSQ_CMD_CLRFLT    2
// Fault class codes of the fault inputs.
`define DSSQ_FCLASS_IMM    2'h1
`define DSSQ_FCLASS_DYN    2'h2
`define DSSQ_FCLASS_CTL    2'h3
// Interrupt event bit positions.
`define DSSQ_EV_UVFAULT    0
`define DSSQ_EV_UVWARN     1
`define DSSQ_EV_STOFAULT   2
`define DSSQ_EV_BRAKE      3
`define DSSQ_EV_FAULT      4
`define DSSQ_EV_WIDTH      5
// Reset values of the threshold and timeout.
`define DSSQ_VTHRESH_RESET 16'h0010
`define DSSQ_TIMEOUT_MS    100
`define DSSQ_CLK_MHZ       100
`define DSSQ_TIMEOUT_CYCLES (`DSSQ_TIMEOUT_MS * 1000 * `DSSQ_CLK_MHZ)
`endif

// file: design/dssq_sync.v
// Purpose: Two-flip-flop synchroniser for a bundle of pin inputs.
// Assumes: Inputs are asynchronous levels.
// Notes:   The first stage is read only by the second stage.
`timescale 1ns/1ns
module dssq_sync #(
  parameter WIDTH = 4
) (
  // Clock and reset.
  input  wire             clk,
  input  wire             rst_n,
  // Asynchronous levels in, synchronised levels out.
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] stage1;

  // Two stages bound the chance of a metastable value reaching the logic.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1   <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule // dssq_sync

// file: design/dssq_top.v
// Purpose: Switch-on and switch-off sequencer of a servo power stage.
// Assumes: Velocity magnitude comes from the control loop on CLOCK.
// Notes:   Pins pass two flip-flops; registers sit on APB.
// Overview of operation
// (RULE_01) With undervoltage mode 0 any undervoltage raises the fault.
// (RULE_02) With mode 1 undervoltage only warns while disabled, else faults.
// (RULE_03) Hardware enable rising with safe-torque-off unpowered faults.
// (RULE_04) Dropping hardware enable disables the stage at once.
// (RULE_05) Disable mode 0 disables at once, brake on threshold or timeout.
// (RULE_06) Disable mode 2 stops under control, then disables the drive.
// (RULE_07) The stop input decelerates, disables and applies the brake.
// (RULE_08) Any stop applies the brake at low velocity or timeout.
// (RULE_09) Immediate brake 1 applies the brake at once on hw disable/fault; the code does so only for faults that coast, not dynamic or controlled ones.
// (RULE_10) Immediate-disable faults cut the stage, brake by the usual rule.
// (RULE_11) Dynamic-braking faults brake dynamically, brake by usual rule.
// (RULE_12) Controlled-stop faults decelerate before disabling.
// (RULE_13) The operator sets disable mode 2 for distinct stop categories.
// (RULE_14) The controller gives stops priority over starts, category 0 first.
// (RULE_15) The controller gives emergency stop top priority; reset no restart.
// (RULE_16) Losing the drive-active status engages the holding brake.
// (RULE_17) Threshold and timeout are settable; timing starts at stop begin.
//
// Added by the designer: the address map and the APB slave port.
`timescale 1ns/1ns
`include "dssq_consts.vh"
module dssq_top #(
  parameter VEL_W           = 16,
  parameter TIMEOUT_CYCLES  = `DSSQ_TIMEOUT_CYCLES
) (
  // Clock and reset.
  input  wire             CLOCK,
  input  wire             RSTN,
  // APB slave.
  input  wire             PSEL,
  input  wire             PENABLE,
  input  wire             PWRITE,
  input  wire [11:0]      PADDR,
  input  wire [31:0]      PWDATA,
  output reg  [31:0]      PRDATA,
  output reg              PREADY,
  output reg              PSLVERR,
  // Pins from the machine and the power section.
  input  wire             HARDWARE_ENABLE_INPUT,
  input  wire             SAFE_TORQUE_OFF_INPUT,
  input  wire             STOP_INPUT,
  input  wire             UNDERVOLTAGE,
  // Fault request from drive monitors, same clock.
  input  wire             FAULT_REQ,
  input  wire [1:0]       FAULT_CLASS,
  // Velocity magnitude from the control loop, same clock.
  input  wire [VEL_W-1:0] VELOCITY,
  // Power stage outputs.
  output reg              POWER_STAGE_ON,
  output reg              DECEL_REQ,
  output reg              DYN_BRAKE,
  output reg              BRAKE_APPLY,
  output reg              DRIVE_ACTIVE,
  output reg              UNDERVOLTAGE_FAULT,
  output reg              UNDERVOLTAGE_WARNING,
  output reg              SAFE_TORQUE_FAULT,
  output reg              IRQ
);
  localparam [4:0] ST_OFF   = 5'h01;
  localparam [4:0] ST_RUN   = 5'h02;
  localparam [4:0] ST_DECEL = 5'h04;
  localparam [4:0] ST_COAST = 5'h08;
  localparam [4:0] ST_DYN   = 5'h10;
  localparam       EVW      = `DSSQ_EV_WIDTH;

  // True in the three states in which the motor runs down.
  function is_stop;
    input [4:0] st;
    begin
      is_stop = (st == ST_DECEL) || (st == ST_COAST) || (st == ST_DYN);
    end
  endfunction

  // Sequencer state, settings and interrupt bookkeeping.
  reg  [4:0]       state;
  reg  [4:0]       next_state;
  reg  [31:0]      ctrl;
  reg  [VEL_W-1:0] vthresh;
  reg  [31:0]      timeout;
  reg  [31:0]      tcount;
  reg  [EVW-1:0]   int_stat;
  reg  [EVW-1:0]   int_mask;
  reg              hw_en_d;
  reg              fault_latched;
  reg              coast_cut;
  wire [3:0]       pins;
  wire             hw_en;
  wire             sto_ok;
  wire             stop_in;
  wire             uv;

  // Pins are asynchronous, so each goes through two flip-flops.
  dssq_sync #(
    .WIDTH    (4)
  ) u_sync (
    .clk      (CLOCK),
    .rst_n    (RSTN),
    .async_in ({UNDERVOLTAGE, STOP_INPUT, SAFE_TORQUE_OFF_INPUT,
                HARDWARE_ENABLE_INPUT}),
    .sync_out (pins)
  );
  assign hw_en   = pins[0];
  assign sto_ok  = pins[1];
  assign stop_in = pins[2];
  assign uv      = pins[3];

  // Decoded APB phases.
  wire wr_acc = PSEL && PENABLE && PWRITE;
  wire setup  = PSEL && !PENABLE;
  wire cmd_wr = wr_acc && (PADDR == `DSSQ_ADDR_CMD);
  wire sw_en  = cmd_wr && PWDATA[`DSSQ_CMD_ENABLE];
  wire sw_dis = cmd_wr && PWDATA[`DSSQ_CMD_DISABLE];
  wire clr_f  = cmd_wr && PWDATA[`DSSQ_CMD_CLRFLT];

  // Control fields and the enable qualification.
  wire       uv_mode  = ctrl[`DSSQ_CTRL_UVMODE];
  wire [1:0] dis_mode = ctrl[`DSSQ_CTRL_DISMODE];
  wire       brk_imm  = ctrl[`DSSQ_CTRL_BRKIMM];
  wire       running  = (state == ST_RUN);
  wire       enabling = sw_en && hw_en && sto_ok;

  // Undervoltage classification by mode.
  wire uv_fault_ev = uv && (!uv_mode || running || sw_en); // RULE_01 RULE_02
  wire uv_warn_ev  = uv && uv_mode && !running && !sw_en;  // RULE_02
  wire sto_ev      = hw_en && !hw_en_d && !sto_ok;         // RULE_03
  wire flt_any     = FAULT_REQ || uv_fault_ev || sto_ev;
  // An undervoltage or torque-off fault is treated as immediate disable unless FAULT_REQ comes in the same cycle.
  wire [1:0] fcls  = FAULT_REQ ? FAULT_CLASS : `DSSQ_FCLASS_IMM;
  wire vel_low     = (VELOCITY < vthresh);
  wire t_out       = (tcount >= timeout);
  wire stopping    = is_stop(state);

  // Sequencer; hardware disable wins over every other stop request.
  always @* begin
    next_state = state;
    case (state)
      ST_OFF: begin
        if (enabling && !flt_any && !fault_latched)
          next_state = ST_RUN;
      end
      ST_RUN: begin
        // Loss of enable outranks faults, and faults the stop input.
        if (!hw_en || !sto_ok)
          next_state = ST_COAST;                           // RULE_04
        else if (flt_any) begin
          case (fcls)
            `DSSQ_FCLASS_DYN: next_state = ST_DYN;         // RULE_11
            `DSSQ_FCLASS_CTL: next_state = ST_DECEL;       // RULE_12
            default:          next_state = ST_COAST;       // RULE_10
          endcase
        end else if (stop_in)
          next_state = ST_DECEL;                           // RULE_07
        else if (sw_dis)
          next_state = (dis_mode == 2'h2) ? ST_DECEL :     // RULE_06
                       ST_COAST;                           // RULE_05
      end
      ST_DECEL: begin
        // A harder stop request cuts a controlled stop short.
        if (!hw_en || !sto_ok || (flt_any && fcls != `DSSQ_FCLASS_CTL))
          next_state = ST_COAST;
        else if (vel_low || t_out)
          next_state = ST_OFF;                             // RULE_08
      end
      ST_COAST, ST_DYN: begin
        if (vel_low || t_out)
          next_state = ST_OFF;                             // RULE_08
      end
      default: next_state = ST_OFF;
    endcase
  end

  // State, stop timer and hardware enable history.
  always @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      state   <= ST_OFF;
      tcount  <= 32'h0000_0000;
      hw_en_d <= 1'b0;
    end else begin
      state   <= next_state;
      hw_en_d <= hw_en;
      // The timer restarts on every entry into a stop state.
      if (!stopping || next_state != state)
        tcount <= 32'h0000_0000;                           // RULE_17
      else if (!t_out)
        tcount <= tcount + 32'h0000_0001;
    end
  end

  // Outputs decoded from the next state so they are registered.
  wire n_stop  = is_stop(next_state);
  // A cut from the enable pin, the torque-off input or a fault; a software
  // disable in mode 0 also coasts but must still wait for the brake rule.
  wire hw_cut  = (next_state == ST_COAST) && (!hw_en || !sto_ok || flt_any);
  wire n_brake = (next_state == ST_OFF) ||                 // RULE_16
                 ((hw_cut || coast_cut) && brk_imm) ||     // RULE_09
                 (n_stop && (vel_low || t_out));           // RULE_08

  // Remember a cut while coasting, so the brake stays closed throughout.
  always @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN)
      coast_cut <= 1'b0;
    else
      coast_cut <= hw_cut || (coast_cut && (next_state == ST_COAST));
  end

  // Registered stage outputs.
  always @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      POWER_STAGE_ON <= 1'b0;
      DECEL_REQ      <= 1'b0;
      DYN_BRAKE      <= 1'b0;
      BRAKE_APPLY    <= 1'b1;
      DRIVE_ACTIVE   <= 1'b0;
    end else begin
      POWER_STAGE_ON <= (next_state == ST_RUN) || (next_state == ST_DECEL);
      DECEL_REQ      <= (next_state == ST_DECEL);
      DYN_BRAKE      <= (next_state == ST_DYN);
      BRAKE_APPLY    <= n_brake;
      DRIVE_ACTIVE   <= (next_state == ST_RUN);
    end
  end

  // Fault flags hold until cleared, a new event winning; the warning follows its event.
  always @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      UNDERVOLTAGE_FAULT   <= 1'b0;
      UNDERVOLTAGE_WARNING <= 1'b0;
      SAFE_TORQUE_FAULT    <= 1'b0;
      fault_latched        <= 1'b0;
    end else begin
      UNDERVOLTAGE_FAULT   <= uv_fault_ev || (UNDERVOLTAGE_FAULT && !clr_f);
      UNDERVOLTAGE_WARNING <= uv_warn_ev;
      SAFE_TORQUE_FAULT    <= sto_ev || (SAFE_TORQUE_FAULT && !clr_f);
      fault_latched        <= flt_any || (fault_latched && !clr_f);
    end
  end

  // Interrupt status, write one to clear, set wins over clear.
  wire [EVW-1:0] ev = {flt_any, n_brake && !BRAKE_APPLY, sto_ev,
                       uv_warn_ev, uv_fault_ev};
  wire [EVW-1:0] w1c = (wr_acc && PADDR == `DSSQ_ADDR_INTSTAT) ?
                       PWDATA[EVW-1:0] : {EVW{1'b0}};
  always @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      int_stat <= {EVW{1'b0}};
      IRQ      <= 1'b0;
    end else begin
      int_stat <= ev | (int_stat & ~w1c);
      IRQ      <= |((ev | (int_stat & ~w1c)) & int_mask);
    end
  end

  // Register writes take effect in the access phase.
  always @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      ctrl     <= `DSSQ_CTRL_RESET;
      vthresh  <= `DSSQ_VTHRESH_RESET;
      timeout  <= TIMEOUT_CYCLES;
      int_mask <= {EVW{1'b0}};
    end else if (wr_acc) begin
      case (PADDR)
        `DSSQ_ADDR_CTRL:    ctrl     <= {28'h0000000, PWDATA[3:0]};
        `DSSQ_ADDR_VTHRESH: vthresh  <= PWDATA[VEL_W-1:0]; // RULE_17
        `DSSQ_ADDR_TIMEOUT: timeout  <= PWDATA;
        `DSSQ_ADDR_INTMASK: int_mask <= PWDATA[EVW-1:0];
        default:            ctrl     <= ctrl;
      endcase
    end
  end

  // Read mux; read data is ready at once, unmapped gives an error.
  reg [31:0] rd;
  reg        bad;
  always @* begin
    rd  = 32'h0000_0000;
    bad = 1'b0;
    case (PADDR)
      `DSSQ_ADDR_CTRL:     rd = ctrl;
      `DSSQ_ADDR_VTHRESH:  rd = {{(32-VEL_W){1'b0}}, vthresh};
      `DSSQ_ADDR_TIMEOUT:  rd = timeout;
      `DSSQ_ADDR_STATUS:   rd = {23'h000000, fault_latched, state,
                                 BRAKE_APPLY, POWER_STAGE_ON, DRIVE_ACTIVE};
      `DSSQ_ADDR_INTSTAT:  rd = {{(32-EVW){1'b0}}, int_stat};
      `DSSQ_ADDR_INTMASK:  rd = {{(32-EVW){1'b0}}, int_mask};
      `DSSQ_ADDR_VELOCITY: rd = {{(32-VEL_W){1'b0}}, VELOCITY};
      `DSSQ_ADDR_CMD:      rd = 32'h0000_0000;
      default:             bad = 1'b1;
    endcase
  end

  // PREADY rises in the first access cycle, giving zero wait states.
  always @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      PRDATA  <= 32'h0000_0000;
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= setup;
      PSLVERR <= setup && bad;
      if (setup && !PWRITE)
        PRDATA <= rd;
    end
  end
endmodule // dssq_top
